// File: hw/htc_pkg.sv
// Purpose: Shared constants and types for the hardened 16-bit timer/counter.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Every offset, field position and count lives here, with the reset values of ctrl, prescale, top and compare.
package htc_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets.
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;     // Mode, enables, clock select.
   localparam logic [7:0] ADDR_PRESCALE = 8'h04; // Prescaler divide value.
   localparam logic [7:0] ADDR_TOP = 8'h08;      // Reload / period value.
   localparam logic [7:0] ADDR_COMPARE = 8'h0c;  // Output compare value.
   localparam logic [7:0] ADDR_COUNT = 8'h10;    // Live count, read only.
   localparam logic [7:0] ADDR_CAPTURE = 8'h14;  // Captured count, read only.
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18; // Sticky events, read only.
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c; // Event enables.
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h20;  // Write one to clear.
   // ----------------------------------------------------------------
   // Control register fields.
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;   // Two bits of mode.
   localparam int CTRL_RUN_BIT = 2;    // Counter runs when set.
   localparam int CTRL_CAPEN_BIT = 3;  // Input capture enabled.
   localparam int CTRL_CLKSEL_BIT = 4; // 0: system clock, 1: counter clock pin.
   localparam int CTRL_DIR_BIT = 5;    // 0: up, 1: down (non-PWM modes).
   localparam int CTRL_BUSEN_BIT = 6;  // Bus interrupt control in effect.
   localparam int CTRL_RSTEN_BIT = 7;  // Direct reset pin enabled.
   localparam int CTRL_WIDTH = 8;
   // Preloaded settings: watchdog mode, running, reset pin enabled.
   localparam logic [7:0] CTRL_RESET = 8'h84;
   localparam logic [15:0] PRESCALE_RESET = 16'h0000;
   localparam logic [15:0] TOP_RESET = 16'hffff;
   localparam logic [15:0] COMPARE_RESET = 16'h8000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   // ----------------------------------------------------------------
   // Interrupt event bit positions.
   // ----------------------------------------------------------------
   localparam int EV_OVF = 0;
   localparam int EV_CMP = 1;
   localparam int EV_CAP = 2;
   localparam int EV_NUM = 3;
   // ----------------------------------------------------------------
   // Modes, one-hot.
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      HTC_WDOG = 4'h1,
      HTC_CTC = 4'h2,
      HTC_FPWM = 4'h4,
      HTC_PFC = 4'h8
   } htc_mode_t;
   // Software settings carried together.
   // The first member is the most significant, so the order runs from bit 7 down to
   // bit 0 and matches the field positions above.
   typedef struct packed {
      logic rst_en;
      logic bus_irq;
      logic dir_down;
      logic clk_sel;
      logic cap_en;
      logic run;
      logic [1:0] mode;
   } htc_ctrl_t;
   // Events raised by the counter core and input capture in one cycle.
   typedef struct packed {
      logic cap;
      logic cmp;
      logic ovf;
   } htc_evt_t;
endpackage : htc_pkg

// File: hw/htc_sync.sv
// Purpose: Two-flop synchroniser for inputs from outside the clock domain.
// Assumes: Input may change at any time relative to mclk_in.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module htc_sync (
   // Clock, reset and enable.
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // Data.
   input wire logic d_in,
   output logic q_out
);
   // ----------------------------------------------------------------
   // Synchroniser stages.
   // ----------------------------------------------------------------
   logic meta; // First stage, may go metastable; read only by q_out.
   // Two stages give a full cycle for metastability to settle.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         meta <= 1'b0;
         q_out <= 1'b0;
      end else if (ce_in) begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule // htc_sync
`default_nettype wire

// File: hw/htc_timer.sv
// Purpose: Hardened 16-bit up/down timer/counter with compare, PWM, capture.
// Assumes: APB slave on mclk_in; the counter clock pin is slow against mclk_in.
// Notes:   Runs stand-alone from preloaded settings when the bus is idle.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module htc_timer (
   // Clock, reset and enable.
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // APB slave.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Asynchronous pins.
   input wire logic counter_clock_in,
   input wire logic direct_reset_n_in,
   input wire logic capture_trigger_in,
   // Outputs.
   output logic waveform_out,
   output logic irq_out,
   output logic wake_irq_out,
   output logic [15:0] count_value_out
);
   // ----------------------------------------------------------------
   // Pin synchronisers.
   // ----------------------------------------------------------------
   logic clk_pin_s; // Counter clock pin after two flops.
   logic rstn_s;    // Direct reset pin after two flops.
   logic cap_s;     // Capture trigger after two flops.
   htc_sync u_sync_clk (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
      .d_in(counter_clock_in), .q_out(clk_pin_s));
   htc_sync u_sync_rst (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
      .d_in(direct_reset_n_in), .q_out(rstn_s));
   htc_sync u_sync_cap (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
      .d_in(capture_trigger_in), .q_out(cap_s));
   // ----------------------------------------------------------------
   // Register state.
   // ----------------------------------------------------------------
   htc_pkg::htc_ctrl_t ctrl; // Mode and enables.
   logic [15:0] prescale;    // Ticks every prescale+1 source edges.
   logic [15:0] top;         // Period / reload value.
   logic [15:0] compare;     // Live compare value.
   logic [15:0] top_buf;     // Software copy, loaded at period end in PWM.
   logic [15:0] compare_buf; // Software copy, loaded at period end in PWM.
   logic [15:0] count;       // The counter itself.
   logic [15:0] capture_value_reg; // Last captured count.
   logic [2:0] irq_status;   // Sticky events.
   logic [2:0] irq_enable;   // Event enables.
   logic dir_dn;             // Current direction in phase-correct mode.
   logic soft_rst;           // Direct reset pin acting this cycle.
   htc_pkg::htc_mode_t mode; // Decoded one-hot mode.
   // A write that completes this cycle.
   logic wr_go;
   assign wr_go = psel_in & penable_in & pwrite_in;
   // The reset pin only acts while its enable is set.
   assign soft_rst = ctrl.rst_en & ~rstn_s;
   // Decode the two mode bits into the one-hot mode.
   always_comb begin
      case (ctrl.mode)
         2'd0: mode = htc_pkg::HTC_WDOG;
         2'd1: mode = htc_pkg::HTC_CTC;
         2'd2: mode = htc_pkg::HTC_FPWM;
         2'd3: mode = htc_pkg::HTC_PFC;
         default: mode = htc_pkg::HTC_WDOG;
      endcase
   end
   // ----------------------------------------------------------------
   // Control registers, preloaded so the block runs without the bus.
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         ctrl <= htc_pkg::CTRL_RESET;
         prescale <= htc_pkg::PRESCALE_RESET;
         top_buf <= htc_pkg::TOP_RESET;
         compare_buf <= htc_pkg::COMPARE_RESET;
         irq_enable <= 3'h0;
      end else if (ce_in && wr_go) begin
         // Register writes take effect in the access phase.
         case (paddr_in)
            htc_pkg::ADDR_CTRL: ctrl <= pwdata_in[htc_pkg::CTRL_WIDTH-1:0];
            htc_pkg::ADDR_PRESCALE: prescale <= pwdata_in[15:0];
            htc_pkg::ADDR_TOP: top_buf <= pwdata_in[15:0];
            htc_pkg::ADDR_COMPARE: compare_buf <= pwdata_in[15:0];
            htc_pkg::ADDR_IRQ_ENABLE: irq_enable <= pwdata_in[2:0];
            default: ;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Clock source selection and prescaler.
   // ----------------------------------------------------------------
   logic clk_pin_d;  // Previous pin level for edge detection.
   logic [15:0] pre_cnt;
   logic src_edge;   // One source event.
   logic tick;       // One prescaled count event.
   assign src_edge = ctrl.clk_sel ? (clk_pin_s & ~clk_pin_d) : 1'b1;
   // A divide value lowered below the running count ends the cycle at once.
   // Otherwise the prescaler would wrap through all 65536 states first.
   assign tick = ctrl.run & src_edge & (pre_cnt >= prescale);
   // Prescaler divides source events by prescale+1.
   always_ff @(posedge mclk_in) begin
      if (rst_in || soft_rst) begin
         pre_cnt <= 16'h0000;
         clk_pin_d <= 1'b0;
      end else if (ce_in) begin
         clk_pin_d <= clk_pin_s;
         if (ctrl.run && src_edge) begin
            pre_cnt <= (pre_cnt >= prescale) ? 16'h0000 : pre_cnt + 16'h0001;
         end
      end
   end
   // ----------------------------------------------------------------
   // Counter core.
   // ----------------------------------------------------------------
   logic pwm_mode;
   logic at_end;     // Count at the period end in the current direction.
   logic next_ovf;
   logic next_cmp;
   assign pwm_mode = (mode == htc_pkg::HTC_FPWM) || (mode == htc_pkg::HTC_PFC);
   // Decide period end and events for the tick.
   always_comb begin
      at_end = 1'b0;
      next_ovf = 1'b0;
      next_cmp = tick & (count == compare);
      case (mode)
         htc_pkg::HTC_WDOG: begin
            at_end = ctrl.dir_down ? (count == 16'h0000) : (count == htc_pkg::COUNT_MAX);
            next_ovf = tick & at_end;
         end
         htc_pkg::HTC_CTC: begin
            at_end = ctrl.dir_down ? (count == 16'h0000) : (count == compare);
            next_ovf = tick & (count == htc_pkg::COUNT_MAX);
         end
         htc_pkg::HTC_FPWM: begin
            at_end = (count == top);
            next_ovf = tick & at_end;
         end
         htc_pkg::HTC_PFC: begin
            at_end = (count == 16'h0000) & dir_dn;
            next_ovf = tick & at_end;
         end
         default: begin
            at_end = 1'b0;
         end
      endcase
   end
   // Count register: reload in the proper direction at the end.
   always_ff @(posedge mclk_in) begin
      if (rst_in || soft_rst) begin
         count <= 16'h0000;
         dir_dn <= 1'b0;
         top <= htc_pkg::TOP_RESET;
         compare <= htc_pkg::COMPARE_RESET;
      end else if (ce_in) begin
         // Outside PWM the buffers act at once; in PWM only at period end.
         if (!pwm_mode || (tick && at_end)) begin
            top <= top_buf;
            compare <= compare_buf;
         end
         if (tick) begin
            case (mode)
               htc_pkg::HTC_PFC: begin
                  // Up to top, back down to zero, then reload.
                  if (!dir_dn && count >= top) begin
                     dir_dn <= 1'b1;
                     count <= count - 16'h0001;
                  end else if (dir_dn && count == 16'h0000) begin
                     dir_dn <= 1'b0;
                     count <= 16'h0001;
                  end else begin
                     count <= dir_dn ? count - 16'h0001 : count + 16'h0001;
                  end
               end
               htc_pkg::HTC_FPWM: begin
                  count <= at_end ? 16'h0000 : count + 16'h0001;
               end
               default: begin
                  // Watchdog and clear-on-match may count either way.
                  if (ctrl.dir_down) begin
                     count <= at_end ? (mode == htc_pkg::HTC_CTC ? compare : htc_pkg::COUNT_MAX)
                        : count - 16'h0001;
                  end else begin
                     count <= at_end ? 16'h0000 : count + 16'h0001;
                  end
               end
            endcase
         end
      end
   end
   // ----------------------------------------------------------------
   // Input capture.
   // ----------------------------------------------------------------
   logic cap_d;      // Previous synchronised level.
   logic cap_evt;
   assign cap_evt = cap_s & ~cap_d & ctrl.cap_en & ~pwm_mode;
   // A newer edge always overwrites, pending or not.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cap_d <= 1'b0;
         capture_value_reg <= 16'h0000;
      end else if (ce_in) begin
         cap_d <= cap_s;
         if (cap_evt) begin
            capture_value_reg <= count;
         end
      end
   end
   // ----------------------------------------------------------------
   // Waveform output.
   // ----------------------------------------------------------------
   // Registered from the count so there are no glitches.
   always_ff @(posedge mclk_in) begin
      if (rst_in || soft_rst) begin
         waveform_out <= 1'b0;
      end else if (ce_in) begin
         if (pwm_mode) begin
            waveform_out <= (count < compare);
         end else if (next_cmp) begin
            waveform_out <= ~waveform_out;
         end
      end
   end
   // ----------------------------------------------------------------
   // Interrupts: sticky status, set wins over clear.
   // ----------------------------------------------------------------
   htc_pkg::htc_evt_t evt;
   logic [2:0] clr;
   logic [2:0] ovf_pulse; // Overflow flag for stand-alone use.
   assign evt = '{cap: cap_evt, cmp: next_cmp, ovf: next_ovf};
   assign clr = (wr_go && paddr_in == htc_pkg::ADDR_IRQ_CLEAR) ? pwdata_in[2:0] : 3'h0;
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         irq_status <= 3'h0;
      end else if (ce_in) begin
         irq_status <= (irq_status & ~clr) | evt;
      end
   end
   assign ovf_pulse = {2'b00, next_ovf};
   // Static and wake-up lines, both registered.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
         wake_irq_out <= 1'b0;
      end else if (ce_in) begin
         if (ctrl.bus_irq) begin
            irq_out <= |(irq_status & irq_enable);
         end else begin
            irq_out <= ovf_pulse[htc_pkg::EV_OVF];
         end
         wake_irq_out <= |(irq_status & irq_enable) | ovf_pulse[htc_pkg::EV_OVF];
      end
   end
   // ----------------------------------------------------------------
   // APB read path, zero wait states.
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         prdata_out <= 32'h00000000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         count_value_out <= 16'h0000;
      end else if (ce_in) begin
         count_value_out <= count;
         // Ready in the access phase's first cycle.
         pready_out <= psel_in & ~penable_in;
         pslverr_out <= 1'b0;
         if (psel_in && !penable_in) begin
            case (paddr_in)
               htc_pkg::ADDR_CTRL: prdata_out <= {24'h000000, ctrl};
               htc_pkg::ADDR_PRESCALE: prdata_out <= {16'h0000, prescale};
               htc_pkg::ADDR_TOP: prdata_out <= {16'h0000, top_buf};
               htc_pkg::ADDR_COMPARE: prdata_out <= {16'h0000, compare_buf};
               htc_pkg::ADDR_COUNT: prdata_out <= {16'h0000, count};
               htc_pkg::ADDR_CAPTURE: prdata_out <= {16'h0000, capture_value_reg};
               htc_pkg::ADDR_IRQ_STATUS: prdata_out <= {29'h00000000, irq_status};
               htc_pkg::ADDR_IRQ_ENABLE: prdata_out <= {29'h00000000, irq_enable};
               htc_pkg::ADDR_IRQ_CLEAR: prdata_out <= 32'h00000000;
               default: begin
                  prdata_out <= 32'h00000000;
                  pslverr_out <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // htc_timer
`default_nettype wire

// File: tb/htc_apb_master.sv
// Purpose: APB master standing in for the fabric logic that drives the timer.
// Assumes: The slave answers with pready_in; every wait is bounded.
// Notes:   Signals change only by non-blocking assignment after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module htc_apb_master (
   // Clock.
   input wire logic clk_in,
   // APB request.
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [7:0] paddr_out,
   output logic [31:0] pwdata_out,
   // APB answer.
   input wire logic [31:0] prdata_in,
   input wire logic pready_in,
   input wire logic pslverr_in
);
   int tmo = 0; // Waits that ran out; the bench counts them as mismatches.
   // The bus idles with no request and no strobe.
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'h00;
      pwdata_out = 32'h0;
   end
   // One whole transfer; the request is held until pready is sampled high or 50 cycles pass.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_in);
      psel_out <= 1'b1;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge clk_in);
      penable_out <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_in !== 1'b1 && n < 50);
      if (pready_in !== 1'b1) tmo++;
      q = prdata_in;
      e = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      // Stale write data would hide a slave that samples late.
      pwdata_out <= ~d;
   endtask
endmodule // htc_apb_master
`default_nettype wire

// File: tb/htc_timer_asserts.sv
// Purpose: Concurrent checks on the timer's bus answers and pin outputs.
// Assumes: Bound to htc_timer; a single clock domain.
// Notes:   Control bits are mirrored from bus writes to know the irq meaning.
`timescale 1ns/10ps
`default_nettype none
module htc_timer_asserts (
   // Clock, reset and enable.
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // APB.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // Pins.
   input wire logic direct_reset_n_in,
   input wire logic irq_out,
   input wire logic [15:0] count_value_out
);
   default clocking dcb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   logic bus_mode; // Bus interrupt control as last written.
   logic pin_rst; // Direct reset pin enable as last written.
   // Mirror of the control bits, updated at the committing edge.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         bus_mode <= 1'b0;
         pin_rst <= 1'b1;
      end else if (psel_in && penable_in && pwrite_in && pready_out &&
                   paddr_in == htc_pkg::ADDR_CTRL) begin
         bus_mode <= pwdata_in[htc_pkg::CTRL_BUSEN_BIT];
         pin_rst <= pwdata_in[htc_pkg::CTRL_RSTEN_BIT];
      end
   end
   property p_setup_ready;
      ce_in && psel_in && !penable_in |=> pready_out;
   endproperty
   a_setup_ready: assert property (p_setup_ready)
      else $error("no ready after setup");
   property p_ready_one;
      pready_out |=> !pready_out;
   endproperty
   a_ready_one: assert property (p_ready_one)
      else $error("ready held too long");
   property p_idle_quiet;
      !psel_in |=> !pready_out;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("ready without request");
   property p_err_ready;
      pslverr_out |-> pready_out;
   endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("error without ready");
   property p_unmapped;
      ce_in && psel_in && !penable_in && paddr_in > htc_pkg::ADDR_IRQ_CLEAR
         |=> pslverr_out && prdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address accepted");
   property p_ovf_pulse;
      ce_in && !bus_mode && $stable(bus_mode) && irq_out |=> !irq_out;
   endproperty
   a_ovf_pulse: assert property (p_ovf_pulse)
      else $error("overflow flag longer than one cycle");
   property p_dreset;
      (pin_rst && !direct_reset_n_in) [*6] |-> count_value_out == 16'h0;
   endproperty
   a_dreset: assert property (p_dreset)
      else $error("count not held by reset pin");
   // Two reset edges in a row, so that flops not yet reset at the first are not judged.
   property p_reset_quiet;
      @(posedge mclk_in) disable iff (1'b0)
         rst_in ##1 rst_in |-> !irq_out && !pready_out && count_value_out == 16'h0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active in reset");
endmodule // htc_timer_asserts
bind htc_timer htc_timer_asserts i_htc_timer_asserts (.mclk_in, .rst_in, .ce_in,
   .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
   .pslverr_out, .direct_reset_n_in, .irq_out, .count_value_out);
`default_nettype wire

// File: tb/htc_timer_tb_top.sv
// Purpose: Self-checking bench for the timer over APB and its pins.
// Assumes: The APB master model owns the bus; pins are driven here.
// Notes:   Each scenario task drives the block and judges the result.
`timescale 1ns/10ps
`default_nettype none
module htc_timer_tb_top;
   logic mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
   logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out, e;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, q;
   logic cclk = 1'b0, drst_n = 1'b1, cap = 1'b0; // Pin stimulus.
   logic waveform_out, irq_out, wake_irq_out;
   logic [15:0] count_value_out, c0, c1;
   int miscompares = 0, n_checks = 0, k, m, hi;
   // The clock runs at 40 MHz.
   initial begin
      forever #12.5 mclk_in = ~mclk_in;
   end
   htc_apb_master i_htc_apb_master (.clk_in(mclk_in), .psel_out(psel_in),
      .penable_out(penable_in), .pwrite_out(pwrite_in), .paddr_out(paddr_in),
      .pwdata_out(pwdata_in), .prdata_in(prdata_out), .pready_in(pready_out),
      .pslverr_in(pslverr_out));
   htc_timer i_htc_timer (.mclk_in, .rst_in, .ce_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
      .counter_clock_in(cclk), .direct_reset_n_in(drst_n), .capture_trigger_in(cap),
      .waveform_out, .irq_out, .wake_irq_out, .count_value_out);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      miscompares += i_htc_apb_master.tmo;
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_htc_apb_master.xfer(1'b1, a, d, q, e);
      if (i_htc_apb_master.tmo != 0) finish_test();
   endtask
   task automatic rd(input logic [7:0] a);
      i_htc_apb_master.xfer(1'b0, a, 32'h0, q, e);
      if (i_htc_apb_master.tmo != 0) finish_test();
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // The count pin only moves while edges are wanted, and rests low.
   task automatic pulse_clk(input int n);
      repeat (n) begin
         tick(3);
         cclk <= 1'b1;
         tick(3);
         cclk <= 1'b0;
      end
   endtask
   // Preloaded values read back, then an unmapped word is refused.
   task automatic s_reset_values();
      logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h24};
      logic [31:0] x [6] = '{32'h84, 32'h0, 32'hffff, 32'h8000, 32'h0, 32'h0};
      for (k = 0; k < 6; k++) begin
         rd(a[k]);
         chk(q, x[k]);
         chk(32'(e), 32'(k == 5));
      end
   endtask
   // Down-counting watchdog wraps; flag, wake line, status, then masking.
   task automatic s_overflow();
      logic iq = 1'b0, wk = 1'b0;
      wr(htc_pkg::ADDR_CTRL, 32'ha4);
      for (k = 0; k < 2000 && !(iq && wk); k++) begin
         tick(1);
         iq |= (irq_out === 1'b1);
         wk |= (wake_irq_out === 1'b1);
      end
      chk(32'(iq), 32'h1);
      chk(32'(wk), 32'h1);
      if (!(iq && wk)) finish_test();
      wr(htc_pkg::ADDR_CTRL, 32'hc0);
      rd(htc_pkg::ADDR_IRQ_STATUS);
      chk(q, 32'h1);
      wr(htc_pkg::ADDR_IRQ_ENABLE, 32'h1);
      tick(3);
      chk(32'(irq_out), 32'h1);
      wr(htc_pkg::ADDR_IRQ_ENABLE, 32'h0);
      tick(3);
      chk(32'(irq_out), 32'h0);
      wr(htc_pkg::ADDR_IRQ_ENABLE, 32'h7);
      wr(htc_pkg::ADDR_IRQ_CLEAR, 32'h7);
      rd(htc_pkg::ADDR_IRQ_STATUS);
      chk(q, 32'h0);
      chk(32'(irq_out), 32'h0);
   endtask
   // Two captures while running; the second replaces the first.
   task automatic s_capture();
      wr(htc_pkg::ADDR_CTRL, 32'h8c);
      for (k = 0; k < 2; k++) begin
         cap <= 1'b1;
         tick(3);
         cap <= 1'b0;
         tick(6);
         rd(htc_pkg::ADDR_CAPTURE);
         c1 = c0;
         c0 = q[15:0];
         rd(htc_pkg::ADDR_COUNT);
         chk(32'(16'(q[15:0] - c0) < 16'd30), 32'h1);
      end
      chk(32'(16'(c0 - c1) > 16'd10), 32'h1);
      rd(htc_pkg::ADDR_IRQ_STATUS);
      chk(32'(q[2]), 32'h1);
   endtask
   // Pin edges through the prescaler, up and then down.
   task automatic s_extclk();
      wr(htc_pkg::ADDR_PRESCALE, 32'h0);
      wr(htc_pkg::ADDR_CTRL, 32'h94);
      tick(4);
      c0 = count_value_out;
      pulse_clk(5);
      tick(4);
      chk(32'(16'(count_value_out - c0)), 32'h5);
      wr(htc_pkg::ADDR_PRESCALE, 32'h1);
      wr(htc_pkg::ADDR_CTRL, 32'hb4);
      c0 = count_value_out;
      pulse_clk(8);
      tick(4);
      chk(32'(16'(c0 - count_value_out)), 32'h4);
   endtask
   // Reset pin clears the count; then clear-on-match and both PWM modes.
   task automatic s_modes();
      wr(htc_pkg::ADDR_CTRL, 32'h80);
      wr(htc_pkg::ADDR_PRESCALE, 32'h0);
      wr(htc_pkg::ADDR_TOP, 32'hf);
      wr(htc_pkg::ADDR_COMPARE, 32'h4);
      drst_n <= 1'b0;
      tick(6);
      chk(32'(count_value_out), 32'h0);
      drst_n <= 1'b1;
      for (m = 1; m < 4; m++) begin
         wr(htc_pkg::ADDR_CTRL, 32'h84 | 32'(m));
         tick(40);
         c0 = 16'h0;
         hi = 0;
         for (k = 0; k < 160; k++) begin
            tick(1);
            if (count_value_out > c0) c0 = count_value_out;
            hi += int'(waveform_out === 1'b1);
         end
         chk(32'(c0), (m == 1) ? 32'h4 : 32'hf);
         if (m < 3) chk(32'(hi), (m == 1) ? 32'd80 : 32'd40);
      end
   endtask
   // Main sequence: five cycles of reset, then every scenario.
   initial begin
      tick(5);
      rst_in <= 1'b0;
      s_reset_values();
      s_overflow();
      s_capture();
      s_extclk();
      s_modes();
      finish_test();
   end
endmodule // htc_timer_tb_top
`default_nettype wire
